//--- core/timer01_pkg.sv
package timer01_pkg;

  localparam logic [7:0] ADDR_RUN_FLAG   = 8'h88;
  localparam logic [7:0] ADDR_MODE       = 8'h89;
  localparam logic [7:0] ADDR_FIRST_LO   = 8'h8a;
  localparam logic [7:0] ADDR_SECOND_LO  = 8'h8b;
  localparam logic [7:0] ADDR_FIRST_HI   = 8'h8c;
  localparam logic [7:0] ADDR_SECOND_HI  = 8'h8d;
  localparam logic [7:0] ADDR_CLK_SEL    = 8'h8e;

  localparam logic [7:0] CLK_SEL_RESET   = 8'h00;
  localparam logic [7:0] CLK_SEL_MASK    = 8'h7b;
  localparam logic [7:0] RUN_FLAG_RESET  = 8'h00;
  localparam logic [7:0] MODE_RESET      = 8'h00;

  localparam int CS_HIGH_SEL  = 6;
  localparam int CS_LOW_SEL   = 5;
  localparam int CS_SECOND    = 4;
  localparam int CS_FIRST     = 3;

  localparam int RF_SECOND_FLAG = 7;
  localparam int RF_SECOND_RUN  = 6;
  localparam int RF_FIRST_FLAG  = 5;
  localparam int RF_FIRST_RUN   = 4;

  localparam int MD_SECOND_GATE = 7;
  localparam int MD_SECOND_CT   = 6;
  localparam int MD_SECOND_LSB  = 4;
  localparam int MD_FIRST_GATE  = 3;
  localparam int MD_FIRST_CT    = 2;
  localparam int MD_FIRST_LSB   = 0;

  localparam logic [1:0] MODE_13BIT  = 2'h0;
  localparam logic [1:0] MODE_16BIT  = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT  = 2'h3;

  localparam logic [1:0] PRE_DIV12 = 2'h0;
  localparam logic [1:0] PRE_DIV4  = 2'h1;
  localparam logic [1:0] PRE_DIV48 = 2'h2;
  localparam logic [1:0] PRE_EXT8  = 2'h3;

  localparam logic [5:0] DIV12_LAST = 6'h0b;
  localparam logic [5:0] DIV4_LAST  = 6'h03;
  localparam logic [5:0] DIV48_LAST = 6'h2f;
  localparam logic [5:0] EXT8_LAST  = 6'h07;

endpackage

//--- core/timer01_top.sv
`timescale 1ns/1ps
module timer01_top
  import timer01_pkg::*;
(
  // Clock, reset and clock enable.
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // Special-function register port.
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  // External pins.
  input  wire logic       first_count_pin,
  input  wire logic       second_count_pin,
  input  wire logic       first_gate_input,
  input  wire logic       second_gate_input,
  input  wire logic       external_clock,
  // Gate polarity from the input configuration logic.
  input  wire logic       first_gate_polarity,
  input  wire logic       second_gate_polarity,
  // Interrupt vector acknowledges.
  input  wire logic       first_isr_ack,
  input  wire logic       second_isr_ack,
  // Reload timer clock choices.
  output logic            reload_timer_high_clk_sel,
  output logic            reload_timer_low_clk_sel,
  // Flags and strobes.
  output logic            first_overflow_flag,
  output logic            second_overflow_flag,
  output logic            first_overflow_strobe,
  output logic            second_overflow_strobe
);
  import timer01_pkg::*;

  logic [7:0] clk_sel_r;
  logic [7:0] run_flag_r;
  logic [7:0] mode_r;
  logic [7:0] rdata_r;

  logic [1:0] cp0_sync_r;
  logic [1:0] cp1_sync_r;
  logic [1:0] gi0_sync_r;
  logic [1:0] gi1_sync_r;
  logic [1:0] ext_sync_r;
  logic       cp0_prev_r;
  logic       cp1_prev_r;
  logic       ext_prev_r;

  logic       cp0_fall;
  logic       cp1_fall;
  logic       ext_edge;
  logic       presc_tick;
  logic       split;
  logic [1:0] mode0;
  logic [1:0] mode1;
  logic       run0_en;
  logic       run1_en;
  logic       tick0;
  logic       tick0_hi;
  logic       tick1;
  logic       set0;
  logic       set1;
  logic       wr_rf;

  timer_cnt_if u0_if ();
  timer_cnt_if u1_if ();

  function automatic logic sfr_hit(input logic [7:0] a);
    sfr_hit = sfr_wr && (sfr_addr == a);
  endfunction

  // Pins cross into the core clock through two flip-flops.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cp0_sync_r <= 2'h0;
      cp1_sync_r <= 2'h0;
      gi0_sync_r <= 2'h0;
      gi1_sync_r <= 2'h0;
      ext_sync_r <= 2'h0;
    end else if (ce) begin
      cp0_sync_r <= {cp0_sync_r[0], first_count_pin};
      cp1_sync_r <= {cp1_sync_r[0], second_count_pin};
      gi0_sync_r <= {gi0_sync_r[0], first_gate_input};
      gi1_sync_r <= {gi1_sync_r[0], second_gate_input};
      ext_sync_r <= {ext_sync_r[0], external_clock};
    end
  end

  // Edges are only seen if each level lasts one cycle.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cp0_prev_r <= 1'b0;
      cp1_prev_r <= 1'b0;
      ext_prev_r <= 1'b0;
    end else if (ce) begin
      cp0_prev_r <= cp0_sync_r[1];
      cp1_prev_r <= cp1_sync_r[1];
      ext_prev_r <= ext_sync_r[1];
    end
  end

  assign cp0_fall = cp0_prev_r && !cp0_sync_r[1];
  assign cp1_fall = cp1_prev_r && !cp1_sync_r[1];
  assign ext_edge = !ext_prev_r && ext_sync_r[1];

  timer_prescaler u_presc (
    .core_clk        (core_clk),
    .rst             (rst),
    .ce              (ce),
    .prescale_select (clk_sel_r[1:0]),
    .ext_edge        (ext_edge),
    .tick            (presc_tick)
  );

  // Register writes.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      clk_sel_r <= CLK_SEL_RESET;
    end else if (ce && sfr_hit(ADDR_CLK_SEL)) begin
      clk_sel_r <= sfr_wdata & CLK_SEL_MASK;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode_r <= MODE_RESET;
    end else if (ce && sfr_hit(ADDR_MODE)) begin
      mode_r <= sfr_wdata;
    end
  end

  assign wr_rf = sfr_hit(ADDR_RUN_FLAG);

  // Overflow flags: a hardware set wins over any clear in the same cycle.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      run_flag_r <= RUN_FLAG_RESET;
    end else if (ce) begin
      if (wr_rf) begin
        run_flag_r <= sfr_wdata;
      end
      if (!wr_rf && first_isr_ack) begin
        run_flag_r[RF_FIRST_FLAG] <= 1'b0;
      end
      if (!wr_rf && second_isr_ack) begin
        run_flag_r[RF_SECOND_FLAG] <= 1'b0;
      end
      if (set0) begin
        run_flag_r[RF_FIRST_FLAG] <= 1'b1;
      end
      if (set1) begin
        run_flag_r[RF_SECOND_FLAG] <= 1'b1;
      end
    end
  end

  // Timer control.
  assign mode0 = mode_r[MD_FIRST_LSB +: 2];
  assign mode1 = mode_r[MD_SECOND_LSB +: 2];
  assign split = (mode0 == MODE_SPLIT);

  assign run0_en = run_flag_r[RF_FIRST_RUN] &&
                   (!mode_r[MD_FIRST_GATE] ||
                    (gi0_sync_r[1] == first_gate_polarity));
  // While split, the second timer runs through its mode field alone.
  assign run1_en = (mode1 != MODE_SPLIT) &&
                   (split || (run_flag_r[RF_SECOND_RUN] &&
                    (!mode_r[MD_SECOND_GATE] ||
                     (gi1_sync_r[1] == second_gate_polarity))));

  assign tick0 = mode_r[MD_FIRST_CT] ? cp0_fall :
                 (clk_sel_r[CS_FIRST] ? 1'b1 : presc_tick);
  // The split high byte follows the second timer's clock choice.
  assign tick0_hi = clk_sel_r[CS_SECOND] ? 1'b1 : presc_tick;
  assign tick1 = (mode_r[MD_SECOND_CT] && !split) ? cp1_fall :
                 (clk_sel_r[CS_SECOND] ? 1'b1 : presc_tick);

  // Setting run never touches the count bytes.
  assign u0_if.inc_lo = run0_en && tick0;
  assign u0_if.inc_hi = split && run_flag_r[RF_SECOND_RUN] && tick0_hi;
  assign u0_if.mode   = mode0;
  assign u0_if.wr_lo  = ce && sfr_hit(ADDR_FIRST_LO);
  assign u0_if.wr_hi  = ce && sfr_hit(ADDR_FIRST_HI);
  assign u0_if.wdata  = sfr_wdata;

  assign u1_if.inc_lo = run1_en && tick1;
  assign u1_if.inc_hi = 1'b0;
  assign u1_if.mode   = mode1;
  assign u1_if.wr_lo  = ce && sfr_hit(ADDR_SECOND_LO);
  assign u1_if.wr_hi  = ce && sfr_hit(ADDR_SECOND_HI);
  assign u1_if.wdata  = sfr_wdata;

  assign set0 = u0_if.ovf;
  assign set1 = split ? u0_if.ovf_hi : u1_if.ovf;

  timer_count_unit u_first (
    .core_clk (core_clk),
    .rst      (rst),
    .ce       (ce),
    .cif      (u0_if)
  );

  timer_count_unit u_second (
    .core_clk (core_clk),
    .rst      (rst),
    .ce       (ce),
    .cif      (u1_if)
  );

  // Register reads, registered on the read strobe.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else if (ce && sfr_rd) begin
      unique case (sfr_addr)
        ADDR_CLK_SEL:   rdata_r <= clk_sel_r & CLK_SEL_MASK;
        ADDR_RUN_FLAG:  rdata_r <= run_flag_r;
        ADDR_MODE:      rdata_r <= mode_r;
        ADDR_FIRST_LO:  rdata_r <= u0_if.cnt_lo;
        ADDR_FIRST_HI:  rdata_r <= u0_if.cnt_hi;
        ADDR_SECOND_LO: rdata_r <= u1_if.cnt_lo;
        ADDR_SECOND_HI: rdata_r <= u1_if.cnt_hi;
        default:        rdata_r <= 8'h00;
      endcase
    end
  end

  assign sfr_rdata                 = rdata_r;
  assign reload_timer_high_clk_sel = clk_sel_r[CS_HIGH_SEL];
  assign reload_timer_low_clk_sel  = clk_sel_r[CS_LOW_SEL];
  assign first_overflow_flag       = run_flag_r[RF_FIRST_FLAG];
  assign second_overflow_flag      = run_flag_r[RF_SECOND_FLAG];
  assign first_overflow_strobe     = u0_if.ovf;
  assign second_overflow_strobe    = u1_if.ovf;

  // Checks.
  sequence lo_at_max;
    ce && mode0 == MODE_RELOAD && u0_if.inc_lo && u0_if.cnt_lo == 8'hff &&
    !u0_if.wr_lo;
  endsequence

  // The reload lands on the wrap edge, before the next tick can move it.
  sequence reload_seen;
    (u0_if.cnt_lo == $past(u0_if.cnt_hi)) ##1 first_overflow_flag;
  endsequence

  resv_bits_zero_a: assert property (
    @(posedge core_clk) disable iff (rst)
    ce && sfr_rd && sfr_addr == ADDR_CLK_SEL |=> sfr_rdata[7] == 1'b0 &&
    sfr_rdata[2] == 1'b0)
    else $error("Unused clock-select bits read non-zero.");

  wrap13_flag_a: assert property (
    @(posedge core_clk) disable iff (rst)
    ce && mode0 == MODE_13BIT && u0_if.inc_lo && !u0_if.wr_lo &&
    !u0_if.wr_hi && u0_if.cnt_hi == 8'hff && u0_if.cnt_lo[4:0] == 5'h1f
    ##1 ce ##1 ce |-> first_overflow_flag)
    else $error("13-bit wrap did not set the first flag.");

  stopped_hold_a: assert property (
    @(posedge core_clk) disable iff (rst)
    ce && !run0_en && !u0_if.wr_lo |=> $stable(u0_if.cnt_lo))
    else $error("First timer counted while disabled.");

  run_no_clear_a: assert property (
    @(posedge core_clk) disable iff (rst)
    ce && wr_rf && sfr_wdata[RF_FIRST_RUN] && !run_flag_r[RF_FIRST_RUN]
    && !split |=> $stable({u0_if.cnt_hi, u0_if.cnt_lo}))
    else $error("Setting run changed the count.");

  reload_copy_a: assert property (
    @(posedge core_clk) disable iff (rst)
    lo_at_max ##1 ce |-> reload_seen)
    else $error("Auto-reload did not copy the high byte.");

  second_halt_a: assert property (
    @(posedge core_clk) disable iff (rst)
    ce && mode1 == MODE_SPLIT && !u1_if.wr_lo && !u1_if.wr_hi
    |=> $stable({u1_if.cnt_hi, u1_if.cnt_lo}))
    else $error("Second timer counted in mode 3.");

  split_no_flag_a: assert property (
    @(posedge core_clk) disable iff (rst)
    ce && split && u1_if.ovf && !u0_if.ovf_hi && !second_overflow_flag
    && !wr_rf |=> !second_overflow_flag)
    else $error("Second timer set its flag while split.");

  isr_clear_a: assert property (
    @(posedge core_clk) disable iff (rst)
    ce && first_isr_ack && !wr_rf && !set0 |=> !first_overflow_flag)
    else $error("Vector acknowledge did not clear the first flag.");

  set_wins_a: assert property (
    @(posedge core_clk) disable iff (rst)
    ce && set1 && (second_isr_ack || wr_rf) |=> second_overflow_flag)
    else $error("Clear beat a simultaneous overflow.");

endmodule

//--- core/timer_cnt_if.sv
`timescale 1ns/1ps
interface timer_cnt_if;
  logic       inc_lo;
  logic       inc_hi;
  logic [1:0] mode;
  logic       wr_lo;
  logic       wr_hi;
  logic [7:0] wdata;
  logic [7:0] cnt_lo;
  logic [7:0] cnt_hi;
  logic       ovf;
  logic       ovf_hi;

  modport unit (input inc_lo, inc_hi, mode, wr_lo, wr_hi, wdata,
                output cnt_lo, cnt_hi, ovf, ovf_hi);
  modport ctrl (output inc_lo, inc_hi, mode, wr_lo, wr_hi, wdata,
                input cnt_lo, cnt_hi, ovf, ovf_hi);
endinterface

//--- core/timer_count_unit.sv
`timescale 1ns/1ps
module timer_count_unit
  import timer01_pkg::*;
(
  // Clock and reset.
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic ce,
  // Count port.
  timer_cnt_if.unit cif
);
  import timer01_pkg::*;

  logic [7:0] lo_r;
  logic [7:0] hi_r;
  logic [7:0] lo_nxt;
  logic [7:0] hi_nxt;
  logic       ovf_r;
  logic       ovf_hi_r;
  logic       wrap;
  logic       wrap_hi;
  logic [12:0] c13;
  logic [15:0] c16;

  always_comb begin
    lo_nxt  = lo_r;
    hi_nxt  = hi_r;
    wrap    = 1'b0;
    wrap_hi = 1'b0;
    c13     = {hi_r, lo_r[4:0]} + 13'h0001;
    c16     = {hi_r, lo_r} + 16'h0001;
    if (cif.inc_lo) begin
      unique case (cif.mode)
        MODE_13BIT: begin
          hi_nxt      = c13[12:5];
          lo_nxt[4:0] = c13[4:0];
          wrap        = (c13 == 13'h0000);
        end
        MODE_16BIT: begin
          {hi_nxt, lo_nxt} = c16;
          wrap = (c16 == 16'h0000);
        end
        MODE_RELOAD: begin
          wrap   = (lo_r == 8'hff);
          lo_nxt = wrap ? hi_r : c16[7:0];
        end
        MODE_SPLIT: begin
          lo_nxt = c16[7:0];
          wrap   = (lo_r == 8'hff);
        end
      endcase
    end
    if (cif.inc_hi && cif.mode == MODE_SPLIT) begin
      hi_nxt  = hi_r + 8'h01;
      wrap_hi = (hi_r == 8'hff);
    end
    // A byte write in the same cycle as a count wins over the count.
    if (cif.wr_lo) begin
      lo_nxt = cif.wdata;
    end
    if (cif.wr_hi) begin
      hi_nxt = cif.wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      lo_r <= 8'h00;
      hi_r <= 8'h00;
    end else if (ce) begin
      lo_r <= lo_nxt;
      hi_r <= hi_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ovf_r    <= 1'b0;
      ovf_hi_r <= 1'b0;
    end else if (ce) begin
      ovf_r    <= wrap;
      ovf_hi_r <= wrap_hi;
    end
  end

  assign cif.cnt_lo = lo_r;
  assign cif.cnt_hi = hi_r;
  assign cif.ovf    = ovf_r;
  assign cif.ovf_hi = ovf_hi_r;

endmodule

//--- core/timer_prescaler.sv
`timescale 1ns/1ps
module timer_prescaler
  import timer01_pkg::*;
(
  // Clock and reset.
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // Control.
  input  wire logic [1:0] prescale_select,
  input  wire logic       ext_edge,
  // Output.
  output logic            tick
);
  import timer01_pkg::*;

  logic [5:0] cnt_r;
  logic       step;
  logic       tick_r;

  function automatic logic [5:0] last_of(input logic [1:0] sel);
    unique case (sel)
      PRE_DIV12: last_of = DIV12_LAST;
      PRE_DIV4:  last_of = DIV4_LAST;
      PRE_DIV48: last_of = DIV48_LAST;
      PRE_EXT8:  last_of = EXT8_LAST;
    endcase
  endfunction

  // External mode advances on synchronised edges only.
  assign step = (prescale_select == PRE_EXT8) ? ext_edge : 1'b1;

  // A selection change may stretch one period; >= keeps it from hanging.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_r  <= 6'h00;
      tick_r <= 1'b0;
    end else if (ce) begin
      tick_r <= 1'b0;
      if (step) begin
        if (cnt_r >= last_of(prescale_select)) begin
          cnt_r  <= 6'h00;
          tick_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 6'h01;
        end
      end
    end
  end

  assign tick = tick_r;

endmodule

//--- dv/pin_model.sv
`timescale 1ns/1ps
module pin_model (
  // Clock.
  input  wire logic core_clk,
  // Pulse requests from the bench.
  input  wire logic first_go,
  input  wire logic second_go,
  // Pins driven towards the timers.
  output logic      first_count_pin,
  output logic      second_count_pin,
  output logic      external_clock
);
  logic [1:0] hold_r;

  initial begin
    first_count_pin  = 1'b1;
    second_count_pin = 1'b1;
    hold_r           = 2'h0;
  end

  // Each level stands three cycles, so one falling edge comes every six
  // cycles: slower than half the core rate, as the sampler needs.
  always @(posedge core_clk) begin
    hold_r <= (hold_r == 2'h2) ? 2'h0 : hold_r + 2'h1;
    if (hold_r == 2'h2 && first_go) begin
      first_count_pin <= ~first_count_pin;
    end
    if (hold_r == 2'h2 && second_go) begin
      second_count_pin <= ~second_count_pin;
    end
  end

  // The oscillator runs free at exactly eight core periods, phase offset.
  initial begin
    external_clock = 1'b0;
    #1.3;
    forever #16 external_clock = ~external_clock;
  end
endmodule

//--- dv/tb_timer01_top.sv
`timescale 1ns/1ps
module tb_timer01_top;
  import timer01_pkg::*;
  logic        core_clk  = 1'b0;
  logic        rst       = 1'b1;
  logic [7:0]  sfr_addr  = 8'h00;
  logic        sfr_wr    = 1'b0;
  logic        sfr_rd    = 1'b0;
  logic [7:0]  sfr_wdata = 8'h00;
  logic [7:0]  sfr_rdata;
  logic        first_gate_enable     = 1'b0;
  logic        pol0      = 1'b1;
  logic        second_gate_enable     = 1'b0;
  logic        pol1      = 1'b1;
  logic        ce        = 1'b1;
  logic        ack0      = 1'b0;
  logic        ack1      = 1'b0;
  logic        go0       = 1'b0;
  logic        go1       = 1'b0;
  logic        pin0, pin1, ext_clk, hi_sel, lo_sel;
  logic        flag0, flag1, strb0, strb1;
  logic        rd_q      = 1'b0;
  logic [15:0] mon_e;
  logic [15:0] exp_q[$];
  logic [7:0]  d, lo_a, hi_a;
  logic        t;
  int          errors    = 0;
  int          compares  = 0;
  int          seed      = 32'hfa7a20c7;
  int          n, k2;
  // Timer, clock select, mode byte, expected overflow spacing in cycles.
  logic [35:0] tbl [10] = '{36'h0_00_02_0030, 36'h0_01_02_0010,
    36'h0_02_02_00c0, 36'h0_03_02_0100, 36'h0_08_02_0004,
    36'h0_08_06_0018, 36'h1_10_20_0004, 36'h1_01_20_0010,
    36'h1_10_60_0018, 36'h0_08_00_2000};

  always #2 core_clk = ~core_clk;

  timer01_top u_timer01_top (
    .core_clk(core_clk), .rst(rst), .ce(ce),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .first_count_pin(pin0), .second_count_pin(pin1),
    .first_gate_input(first_gate_enable), .second_gate_input(second_gate_enable),
    .external_clock(ext_clk),
    .first_gate_polarity(pol0), .second_gate_polarity(pol1),
    .first_isr_ack(ack0), .second_isr_ack(ack1),
    .reload_timer_high_clk_sel(hi_sel), .reload_timer_low_clk_sel(lo_sel),
    .first_overflow_flag(flag0), .second_overflow_flag(flag1),
    .first_overflow_strobe(strb0), .second_overflow_strobe(strb1));

  pin_model u_pin_model (
    .core_clk(core_clk), .first_go(go0), .second_go(go1),
    .first_count_pin(pin0), .second_count_pin(pin1),
    .external_clock(ext_clk));

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    compares++;
    if (seen !== want) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic test_done;
    $display("Counts: %0d compares, %0d errors", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    sfr_addr  <= a;
    sfr_wdata <= v;
    sfr_wr    <= 1'b1;
    @(posedge core_clk);
    sfr_wr    <= 1'b0;
  endtask

  // The note holds the mask in the upper byte and the value in the lower.
  task automatic rd(input logic [7:0] a, input logic [15:0] note);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    exp_q.push_back(note);
    @(posedge core_clk);
    sfr_rd   <= 1'b0;
  endtask

  function automatic logic ev(input logic tm, input logic f);
    if (f) begin
      return tm ? flag1 : flag0;
    end
    return tm ? strb1 : strb0;
  endfunction

  task automatic wait_ev(input logic tm, input logic f, input int lim,
                         output int cnt);
    cnt = 0;
    do begin
      @(posedge core_clk);
      cnt++;
    end while (ev(tm, f) !== 1'b1 && cnt < lim);
    if (cnt >= lim) begin
      errors++;
      test_done();
    end
  endtask

  // Read data lands the cycle after the strobe is taken.
  always @(posedge core_clk) begin
    if (rd_q) begin
      mon_e = exp_q.pop_front();
      check({8'h00, sfr_rdata & mon_e[15:8]}, {8'h00, mon_e[7:0]});
    end
    rd_q <= sfr_rd;
  end

  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    for (int a = 8'h88; a <= 8'h8e; a++) begin
      rd(a[7:0], 16'hff00);
    end
    rd(8'h90, 16'hff00);
    $display("Test done: reset values");

    repeat (4) begin
      d = $random(seed);
      wr(8'h8e, d);
      rd(8'h8e, {8'hff, d & 8'h7b});
      check({14'h0, hi_sel, lo_sel}, {14'h0, d[6:5]});
      d = $random(seed);
      wr(8'h8d, d);
      rd(8'h8d, {8'hff, d});
      wr(8'h90, d);
      rd(8'h90, 16'hff00);
    end
    $display("Test done: register access");

    foreach (tbl[k]) begin
      t    = tbl[k][32];
      lo_a = t ? 8'h8b : 8'h8a;
      hi_a = t ? 8'h8d : 8'h8c;
      wr(8'h8e, tbl[k][31:24]);
      wr(lo_a, 8'hfc);
      wr(hi_a, 8'hfc);
      wr(8'h89, tbl[k][23:16]);
      go0 <= ~t;
      go1 <= t;
      wr(8'h88, t ? 8'h40 : 8'h10);
      wait_ev(t, 1'b0, 20000, n);
      wait_ev(t, 1'b0, 20000, n);
      check(n[15:0], tbl[k][15:0]);
      if (tbl[k][17] | tbl[k][21]) begin
        rd(hi_a, 16'hfffc);
      end else begin
        rd(lo_a, 16'he0e0);
      end
      check({15'h0, ev(t, 1'b1)}, 16'h1);
      wr(8'h88, t ? 8'h80 : 8'h20);
      repeat (3) @(posedge core_clk);
      ack0 <= ~t;
      ack1 <= t;
      @(posedge core_clk);
      ack0 <= 1'b0;
      ack1 <= 1'b0;
      repeat (2) @(posedge core_clk);
      check({15'h0, ev(t, 1'b1)}, 16'h0);
      $display("Test done: spacing entry %0d", k);
    end
    go0 <= 1'b0;
    go1 <= 1'b0;

    wr(8'h89, 8'h09);
    wr(8'h8e, 8'h08);
    wr(8'h8a, 8'h00);
    wr(8'h8c, 8'hff);
    wr(8'h88, 8'h10);
    repeat (20) @(posedge core_clk);
    rd(8'h8a, 16'hff00);
    first_gate_enable <= 1'b1;
    wait_ev(1'b0, 1'b0, 400, n);
    check({15'h0, n >= 256 && n <= 264}, 16'h1);
    wr(8'h88, 8'h00);
    rd(8'h88, 16'hff00);
    $display("Test done: gate and 16-bit");

    // A frozen clock enable must hold the count, so the wait after it stays 17 cycles.
    wr(8'h8a, 8'hf0);
    wr(8'h8c, 8'hff);
    wr(8'h88, 8'h10);
    ce <= 1'b0;
    repeat (100) @(posedge core_clk);
    ce <= 1'b1;
    wait_ev(1'b0, 1'b0, 40, n);
    check(n[15:0], 16'h0011);
    $display("Test done: clock enable");

    wr(8'h89, 8'h23);
    wr(8'h8e, 8'h18);
    wr(8'h8a, 8'hfc);
    wr(8'h8c, 8'h00);
    wr(8'h8b, 8'hfc);
    wr(8'h8d, 8'hfc);
    wr(8'h88, 8'h10);
    wait_ev(1'b0, 1'b0, 600, n);
    wait_ev(1'b0, 1'b0, 600, n);
    check(n[15:0], 16'h0100);
    wait_ev(1'b1, 1'b0, 20, n);
    wait_ev(1'b1, 1'b0, 20, n);
    check(n[15:0], 16'h0004);
    check({15'h0, flag1}, 16'h0);
    wr(8'h88, 8'h50);
    wait_ev(1'b1, 1'b1, 300, n);
    check({15'h0, n >= 257 && n <= 259}, 16'h1);
    wr(8'h89, 8'h33);
    repeat (4) @(posedge core_clk);
    k2 = 0;
    repeat (300) begin
      @(posedge core_clk);
      if (strb1 !== 1'b0) begin
        k2++;
      end
    end
    check(k2[15:0], 16'h0);
    $display("Test done: split mode");

    // Second timer gated by its own input, set active low.
    pol1  <= 1'b0;
    second_gate_enable <= 1'b1;
    wr(8'h8e, 8'h10);
    wr(8'h89, 8'h90);
    wr(8'h8b, 8'hf0);
    wr(8'h8d, 8'hff);
    wr(8'h88, 8'h40);
    repeat (20) @(posedge core_clk);
    rd(8'h8b, 16'hfff0);
    second_gate_enable <= 1'b0;
    wait_ev(1'b1, 1'b0, 40, n);
    check({15'h0, n >= 17 && n <= 20}, 16'h1);
    $display("Test done: second gate");
    repeat (4) @(posedge core_clk);
    test_done();
  end
endmodule
